// ===== ddsp_regs.vh
// Register offsets, field positions and reset values of the digit and standard pin ports.
// Included by the port block; defines only.
`ifndef DDSP_REGS_VH
`define DDSP_REGS_VH

// ----------------------------------------
// Register byte addresses (APB)
// ----------------------------------------
`define DDSP_STD_DATA_ADDR 16'hFFD9
`define DDSP_STD_DIR_ADDR 16'hFFE9
`define DDSP_STD_FSEL_ADDR 16'hFFEC
`define DDSP_DIGIT_DATA_ADDR 16'hFFD7
`define DDSP_DISP_CTRL_ADDR 16'hFFF0
`define DDSP_TIMER_CTRL_ADDR 16'hFFF4
`define DDSP_STATUS_ADDR 16'hFFF8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DDSP_RST_BYTE 8'h00

// ----------------------------------------
// Function-select field positions
// ----------------------------------------
`define DDSP_FSEL_UPDOWN 7
`define DDSP_FSEL_SER2_OUT 6
`define DDSP_FSEL_SER2_IN 5
`define DDSP_FSEL_SER2_CLK 4
`define DDSP_FSEL_SER1_OUT 3
`define DDSP_FSEL_SER1_IN 2
`define DDSP_FSEL_SER1_CLK 1
`define DDSP_FSEL_PWM 0

// ----------------------------------------
// Display control and timer control fields
// ----------------------------------------
`define DDSP_DISP_RANGE_LSB 0
`define DDSP_DISP_RANGE_MSB 3
`define DDSP_DISP_PIN_EN 4
`define DDSP_DISP_CTRL_EN 5
`define DDSP_TMR_DIR_MODE 0

`endif

// ===== ddsp_pin_cell.v
// One general-purpose pin with optional peripheral takeover.
// Assumes peripheral controls are already resolved by the parent.
`timescale 1ns/1ns
module ddsp_pin_cell (
	input wire ref_clk_i,
	input wire reset_i,
	input wire active_i,
	input wire alt_sel_i,
	input wire alt_drive_i,
	input wire alt_oe_i,
	input wire gp_oe_i,
	input wire gp_data_i,
	input wire pin_in_i,
	input wire read_latch_i,
	output reg pin_out_o,
	output reg pin_oe_o,
	output wire read_o
);
	// Registered pin drive; released outside active mode
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			pin_out_o <= 1'b0;
			pin_oe_o <= 1'b0;
		end else if (!active_i) begin
			pin_out_o <= 1'b0;
			pin_oe_o <= 1'b0;
		end else if (alt_sel_i) begin
			pin_out_o <= alt_drive_i;
			pin_oe_o <= alt_oe_i;
		end else begin
			pin_out_o <= gp_data_i;
			pin_oe_o <= gp_oe_i;
		end
	end

	assign read_o = read_latch_i ? gp_data_i : pin_in_i;
endmodule

// ===== ddsp_port.v
// Digit (high-voltage) port and standard port with function select, APB slave.
// Assumes pin inputs synchronous to ref_clk_i; reset is synchronous, active high.
//
// Overview of operation
// - The digit port has an eight-bit read/write data latch, cleared by reset.
// - With the display pin enable clear, all digit port pins are general I/O.
// - With it set, pins chosen by the four-bit digit range are digit outputs and the rest stay general I/O.
// - Reading a pin that is a digit output returns its latch bit, not the pin level.
// - Clearing the display pin enable while the display runs hands pins back to general I/O at once.
// - Digit pins float during reset, standby and subactive, and work normally only in active mode.
// - A second eight-pin standard port shares pins with serial, PWM and timer signals.
// - An eight-bit read/write function-select register picks each standard pin's role, reset to zero.
// - Function-select bits 7..0 are up/down, serial-2 out, serial-2 in, serial-2 clock, serial-1 out, in, clock, PWM.
// - Function-select bit 7 routes standard pin 7 to the timer C direction input, else general I/O.
// - The direction pin is used by the timer only when the direction control mode bit is set.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ns
`include "ddsp_regs.vh"
module ddsp_port #(
	parameter WIDTH = 8
) (
	input wire ref_clk_i,
	input wire reset_i,
	input wire [15:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire [3:0] pstrb,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire active_mode_i,
	input wire [WIDTH-1:0] digit_pin_i,
	output wire [WIDTH-1:0] digit_pin_o,
	output wire [WIDTH-1:0] digit_pin_oe_o,
	input wire [WIDTH-1:0] digit_drive_i,
	input wire [WIDTH-1:0] std_pin_i,
	output wire [WIDTH-1:0] std_pin_o,
	output wire [WIDTH-1:0] std_pin_oe_o,
	input wire [WIDTH-1:0] std_alt_out_i,
	input wire [WIDTH-1:0] std_alt_oe_i,
	output reg [WIDTH-1:0] std_alt_in_o,
	output reg count_direction_o,
	output reg count_direction_valid_o,
	output reg display_controller_enable_o
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] digit_port_data_reg;
	reg [7:0] std_port_data_reg;
	reg [7:0] std_port_direction_reg;
	reg [7:0] std_port_function_select_reg;
	reg [3:0] digit_range_reg;
	reg display_pin_enable_reg;
	reg display_controller_enable_reg;
	reg direction_control_mode_reg;
	reg [7:0] digit_sel_next;
	reg [31:0] rdata_next;
	reg hit_next;
	wire [WIDTH-1:0] digit_read;
	wire [WIDTH-1:0] std_read;
	wire wr_en;
	wire rd_setup;
	integer k;

	assign wr_en = psel && penable && pwrite && pready && pstrb[0];
	assign rd_setup = psel && !penable;

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			digit_port_data_reg <= `DDSP_RST_BYTE;
			std_port_data_reg <= `DDSP_RST_BYTE;
			std_port_direction_reg <= `DDSP_RST_BYTE;
			std_port_function_select_reg <= `DDSP_RST_BYTE;
			digit_range_reg <= 4'h0;
			display_pin_enable_reg <= 1'b0;
			display_controller_enable_reg <= 1'b0;
			direction_control_mode_reg <= 1'b0;
		end else if (wr_en) begin
			case (paddr)
				`DDSP_DIGIT_DATA_ADDR: digit_port_data_reg <= pwdata[7:0];
				`DDSP_STD_DATA_ADDR: std_port_data_reg <= pwdata[7:0];
				`DDSP_STD_DIR_ADDR: std_port_direction_reg <= pwdata[7:0];
				`DDSP_STD_FSEL_ADDR: std_port_function_select_reg <= pwdata[7:0];
				`DDSP_DISP_CTRL_ADDR: begin
					digit_range_reg <= pwdata[`DDSP_DISP_RANGE_MSB:`DDSP_DISP_RANGE_LSB];
					display_pin_enable_reg <= pwdata[`DDSP_DISP_PIN_EN];
					display_controller_enable_reg <= pwdata[`DDSP_DISP_CTRL_EN];
				end
				`DDSP_TIMER_CTRL_ADDR: direction_control_mode_reg <= pwdata[`DDSP_TMR_DIR_MODE];
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Digit pin selection
	// ----------------------------------------
	// Range field n selects digit pins 0..n (capped at port width)
	always @* begin
		digit_sel_next = 8'h00;
		for (k = 0; k < WIDTH; k = k + 1) begin
			if (display_pin_enable_reg && (k <= digit_range_reg)) begin
				digit_sel_next[k] = 1'b1;
			end
		end
		if (!display_pin_enable_reg) begin
			digit_sel_next = 8'h00;
		end
	end

	// ----------------------------------------
	// Pin cells
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
			// Digit pins: drive from display when selected, float outside active mode
			ddsp_pin_cell u_digit (
				.ref_clk_i(ref_clk_i),
				.reset_i(reset_i),
				.active_i(active_mode_i),
				.alt_sel_i(digit_sel_next[g]),
				.alt_drive_i(digit_drive_i[g]),
				.alt_oe_i(1'b1),
				.gp_oe_i(1'b1),
				.gp_data_i(digit_port_data_reg[g]),
				.pin_in_i(digit_pin_i[g]),
				.read_latch_i(digit_sel_next[g]),
				.pin_out_o(digit_pin_o[g]),
				.pin_oe_o(digit_pin_oe_o[g]),
				.read_o(digit_read[g])
			);
			// Standard pins: peripheral takeover per function-select bit
			ddsp_pin_cell u_std (
				.ref_clk_i(ref_clk_i),
				.reset_i(reset_i),
				.active_i(1'b1),
				.alt_sel_i(std_port_function_select_reg[g]),
				.alt_drive_i(std_alt_out_i[g]),
				.alt_oe_i(std_alt_oe_i[g]),
				.gp_oe_i(std_port_direction_reg[g]),
				.gp_data_i(std_port_data_reg[g]),
				.pin_in_i(std_pin_i[g]),
				.read_latch_i(std_port_direction_reg[g] & ~std_port_function_select_reg[g]),
				.pin_out_o(std_pin_o[g]),
				.pin_oe_o(std_pin_oe_o[g]),
				.read_o(std_read[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Peripheral side
	// ----------------------------------------
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			std_alt_in_o <= 8'h00;
			count_direction_o <= 1'b0;
			count_direction_valid_o <= 1'b0;
			display_controller_enable_o <= 1'b0;
		end else begin
			std_alt_in_o <= std_pin_i & std_port_function_select_reg;
			count_direction_o <= std_port_function_select_reg[`DDSP_FSEL_UPDOWN] &
				direction_control_mode_reg & std_pin_i[`DDSP_FSEL_UPDOWN];
			count_direction_valid_o <= std_port_function_select_reg[`DDSP_FSEL_UPDOWN] &
				direction_control_mode_reg;
			display_controller_enable_o <= display_controller_enable_reg;
		end
	end

	// ----------------------------------------
	// APB read and response
	// ----------------------------------------
	always @* begin
		hit_next = 1'b1;
		rdata_next = 32'h0000_0000;
		case (paddr)
			`DDSP_DIGIT_DATA_ADDR: rdata_next[7:0] = digit_read;
			`DDSP_STD_DATA_ADDR: rdata_next[7:0] = std_read;
			`DDSP_STD_DIR_ADDR: rdata_next = 32'h0000_0000;
			`DDSP_STD_FSEL_ADDR: rdata_next[7:0] = std_port_function_select_reg;
			`DDSP_DISP_CTRL_ADDR: rdata_next[5:0] = {display_controller_enable_reg,
				display_pin_enable_reg, digit_range_reg};
			`DDSP_TIMER_CTRL_ADDR: rdata_next[0] = direction_control_mode_reg;
			`DDSP_STATUS_ADDR: rdata_next[7:0] = digit_sel_next;
			default: hit_next = 1'b0;
		endcase
	end

	// One wait state: setup, access with pready low, then pready high
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= !hit_next;
			prdata <= pwrite ? 32'h0000_0000 : rdata_next;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			if (rd_setup) begin
				prdata <= 32'h0000_0000;
			end
		end
	end
endmodule

// ===== ddsp_port_sva.sv
// Checker for the pin port block.
// Assumes binding onto the port block.
`timescale 1ns/1ns
module ddsp_port_sva #(
	parameter WIDTH = 8
) (
	input logic ref_clk_i, reset_i, psel, penable, pwrite, pready, pslverr, active_mode_i,
	input logic [31:0] prdata,
	input logic [WIDTH-1:0] digit_pin_o, digit_pin_oe_o, std_pin_i,
	input logic count_direction_o, count_direction_valid_o, display_controller_enable_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	a_ready_one_wait: assert property (psel && penable && !pready |=> pready) else $error("late answer");
	a_ready_single: assert property (pready |=> !pready) else $error("long answer");
	a_ready_cause: assert property (pready |-> $past(psel && penable)) else $error("stray answer");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
	a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error data");
	a_idle_release: assert property (!active_mode_i |=> digit_pin_oe_o == 0 && digit_pin_o == 0)
		else $error("digit pins driven when idle");
	a_dir_follow_pin: assert property (count_direction_valid_o |-> count_direction_o == $past(std_pin_i[7]))
		else $error("direction mismatch");
	a_enable_after_write: assert property ($changed(display_controller_enable_o) |->
		$past(pwrite && pready) || $past(pwrite && pready, 2)) else $error("enable moved alone");
	cover property (pslverr);
	cover property (count_direction_valid_o);
	cover property ($fell(display_controller_enable_o));
endmodule
bind ddsp_port ddsp_port_sva #(.WIDTH(WIDTH)) u_ddsp_port_sva (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .prdata(prdata),
	.active_mode_i(active_mode_i), .digit_pin_o(digit_pin_o), .digit_pin_oe_o(digit_pin_oe_o),
	.std_pin_i(std_pin_i), .count_direction_o(count_direction_o),
	.count_direction_valid_o(count_direction_valid_o), .display_controller_enable_o(display_controller_enable_o));

// ===== ddsp_pin_load.sv
// Pin loads on both ports.
// Assumes pin drive and enable of the port block.
`timescale 1ns/1ns
module ddsp_pin_load (
	input logic [7:0] dig_out_i, dig_oe_i, std_out_i, std_oe_i, ext_i,
	output logic [7:0] dig_pin_o, std_pin_o
);
	// Released digit pins pulled down
	assign dig_pin_o = dig_out_i & dig_oe_i;
	assign std_pin_o = (std_out_i & std_oe_i) | (ext_i & ~std_oe_i);
endmodule

// ===== ddsp_port_tb_top.sv
// Testbench of the pin port block with an integer register model.
// Assumes the pin load model and the bound checker.
`timescale 1ns/1ns
module ddsp_port_tb_top;
	logic ref_clk_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0, active_mode_i = 1;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, cdir, cval, dce;
	logic [7:0] dpi, dpo, doe, ddrv = 8'h00, spi, spo, soe, ext = 8'h00, alt_in;
	logic [7:0] alt_out = 8'h00, alt_oe = 8'h00;
	int bad_count = 0, comparisons = 0, cycles = 0, m_dig, m_fsel, m_data, n, mask;
	initial forever #20 ref_clk_i = ~ref_clk_i;
	ddsp_port u_ddsp_port (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.active_mode_i(active_mode_i), .digit_pin_i(dpi), .digit_pin_o(dpo), .digit_pin_oe_o(doe),
		.digit_drive_i(ddrv), .std_pin_i(spi), .std_pin_o(spo), .std_pin_oe_o(soe), .std_alt_out_i(alt_out),
		.std_alt_oe_i(alt_oe), .std_alt_in_o(alt_in), .count_direction_o(cdir), .count_direction_valid_o(cval),
		.display_controller_enable_o(dce));
	ddsp_pin_load u_ddsp_pin_load (.dig_out_i(dpo), .dig_oe_i(doe), .std_out_i(spo), .std_oe_i(soe), .ext_i(ext),
		.dig_pin_o(dpi), .std_pin_o(spi));
	task automatic chk(input string nm, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wrap_up;
		$display("mismatches %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
		@(posedge ref_clk_i);
		psel <= 1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1;
		do @(posedge ref_clk_i); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] e, input logic er);
		apb(a, 0, 0);
		chk(nm, rd, e);
		chk(nm, err, er);
	endtask
	task automatic tick;
		repeat (3) @(posedge ref_clk_i);
		#1;
	endtask
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles > 5000) begin
			bad_count++;
			wrap_up;
		end
	end
	initial begin
		n = $urandom(16);
		repeat (12) @(posedge ref_clk_i);
		reset_i <= 0;
		rdchk("std data", 16'hFFD9, 0, 0);
		rdchk("direction", 16'hFFE9, 0, 0);
		rdchk("fsel", 16'hFFEC, 0, 0);
		rdchk("digit data", 16'hFFD7, 0, 0);
		rdchk("unmapped", 16'hFF00, 0, 1);
		m_dig = $urandom & 255;
		apb(16'hFFD7, 1, m_dig);
		rdchk("digit rw", 16'hFFD7, m_dig, 0);
		tick;
		chk("digit gp pins", dpo, m_dig);
		@(posedge ref_clk_i);
		ext <= 8'($urandom);
		alt_out <= 8'($urandom);
		// Pin 7 carries an input function, so its peripheral never drives
		alt_oe <= 8'($urandom) & 8'h7F;
		for (int i = 0; i < 9; i++) begin
			m_fsel = (i < 8) ? (1 << i) : ($urandom & 255);
			apb(16'hFFEC, 1, m_fsel);
			rdchk("fsel rw", 16'hFFEC, m_fsel, 0);
			tick;
			chk("alt out", spo, m_fsel & alt_out);
			chk("alt oe", soe, m_fsel & alt_oe);
			chk("alt in", alt_in, m_fsel & ((alt_out & alt_oe) | (ext & ~alt_oe)));
		end
		apb(16'hFFEC, 1, 32'h80);
		for (int i = 0; i < 2; i++) begin
			apb(16'hFFF4, 1, i);
			tick;
			chk("dir valid", cval, i);
			chk("dir value", cdir, i & ext[7]);
		end
		rdchk("dir mode", 16'hFFF4, 1, 0);
		apb(16'hFFEC, 1, 0);
		tick;
		chk("dir off", cval, 0);
		m_data = $urandom & 255;
		apb(16'hFFD9, 1, m_data);
		apb(16'hFFE9, 1, 32'hFF);
		rdchk("direction wo", 16'hFFE9, 0, 0);
		rdchk("std latch", 16'hFFD9, m_data, 0);
		tick;
		chk("std pins", spo, m_data);
		chk("std oe", soe, 8'hFF);
		n = $urandom & 15;
		mask = (n >= 7) ? 255 : (1 << (n + 1)) - 1;
		ddrv <= 8'(~m_dig);
		apb(16'hFFF0, 1, n);
		apb(16'hFFF0, 1, n | 32'h30);
		tick;
		chk("ctrl enable", dce, 1);
		chk("digit pins", dpo, (m_dig ^ mask) & 255);
		rdchk("digit read", 16'hFFD7, m_dig, 0);
		rdchk("ctrl read", 16'hFFF0, n | 32'h30, 0);
		rdchk("digit mask", 16'hFFF8, mask, 0);
		apb(16'hFFF0, 1, n | 32'h20);
		tick;
		chk("handback", dpo, m_dig);
		rdchk("handback mask", 16'hFFF8, 0, 0);
		@(posedge ref_clk_i);
		active_mode_i <= 0;
		tick;
		chk("idle oe", doe, 0);
		chk("idle pins", dpo, 0);
		wrap_up;
	end
endmodule
